/* File: tcs_pkg.sv */
// shared constants for the transmit clock and sync interface
`default_nettype none
package tcs_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_PERIOD_LO = 4'h2;
    localparam logic [3:0] ADDR_PERIOD_HI = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_COUNT_LO = 4'h5;
    localparam logic [3:0] ADDR_COUNT_HI = 4'h6;

    // control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_LOOPBACK = 2;
    localparam int CTRL_SYNC_OUT = 3;
    localparam int CTRL_CC_BOUNDARY = 4;
    localparam int CTRL_OUTPUT_FORMAT = 5;
    localparam int CTRL_PLL_PIN_SEL = 6;

    // mode register fields
    localparam int MODE_LINE_LSB = 0;
    localparam int MODE_CLOCK_LOSS = 2;

    // status register fields
    localparam int STAT_CLOCK_LOSS = 0;
    localparam int STAT_SYNC_LEVEL = 1;
    localparam int STAT_TXCLK_LEVEL = 2;
    localparam int STAT_PLL_LEVEL = 3;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // T1 frame of 193 bits, counted from zero
    localparam logic [15:0] PERIOD_RESET = 16'h00C0;

    // transmit clock sources
    typedef enum logic [1:0] {
        TCS_SRC_PLL,
        TCS_SRC_PIN,
        TCS_SRC_RECOVERED,
        TCS_SRC_SPARE
    } tcs_src_t;

    // line modes
    typedef enum logic [1:0] {
        TCS_LINE_T1,
        TCS_LINE_E1,
        TCS_LINE_CC,
        TCS_LINE_6312
    } tcs_line_t;

    // composite clock boundaries in 64kHz bit periods, counted from zero
    localparam logic [15:0] CC_8K_LAST = 16'h0007;
    localparam logic [15:0] CC_400_LAST = 16'h009F;

    // loss of transmit clock timing
    localparam int MCLK_KHZ = 125000;
    localparam int SCALED_MCLK_KHZ = 2048;
    localparam int LOSS_PERIODS = 15;
    localparam int LOSS_CYCLES_INT = (LOSS_PERIODS * MCLK_KHZ) / SCALED_MCLK_KHZ;
    localparam logic [11:0] LOSS_CYCLES = LOSS_CYCLES_INT[11:0];
    localparam logic [11:0] LOSS_COUNT_RESET = 12'h000;

    // input synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage
`default_nettype wire

/* File: tcs_sync2.sv */
// two-flop level synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none
module tcs_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            // stage1 is read only by stage2
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate

endmodule // tcs_sync2
`default_nettype wire

/* File: tcs_tx_interface.sv */
// transmit clock selection, serial data and boundary sync interface
`timescale 1ns/100ps
`default_nettype none
module tcs_tx_interface (
    // system clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // transmit PLL clock domain
    input wire logic pllClk,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // clock pins
    input wire logic tx_primary_clock_in,
    input wire logic rxRecoveredClk,
    output logic tx_clock_out_pin,
    output logic pllClockOutPin,
    // serial data and boundary sync pins
    input wire logic tx_serial_data_in,
    input wire logic syncPinIn,
    output logic tx_boundary_sync_pin,
    output logic syncPinOe,
    // line data pins
    output logic tx_positive_rail_out,
    output logic tx_negative_rail_out,
    // frame-loss indicator
    input wire logic rxFrameLoss,
    output logic frame_loss_indicator_pin,
    // formatter side, same clock as mclk
    input wire logic fmtPos,
    input wire logic fmtNeg,
    input wire logic fmtNrz,
    output logic txDataBit,
    output logic txDataValid,
    output logic txFrameStart
);

    // registers
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [15:0] syncPeriod;

    tcs_pkg::tcs_src_t clkSource;
    tcs_pkg::tcs_line_t lineMode;
    logic remoteLoopback;
    logic syncIsOutput;
    logic cc_boundary_select_bit;
    logic output_format_select_bit;
    logic pllPinSelTxClk;
    logic tx_clock_loss_mode;
    logic isFramed;

    assign clkSource = tcs_pkg::tcs_src_t'(ctrl[tcs_pkg::CTRL_SRC_LSB +: 2]);
    assign remoteLoopback = ctrl[tcs_pkg::CTRL_LOOPBACK];
    assign syncIsOutput = ctrl[tcs_pkg::CTRL_SYNC_OUT];
    assign cc_boundary_select_bit = ctrl[tcs_pkg::CTRL_CC_BOUNDARY];
    assign output_format_select_bit = ctrl[tcs_pkg::CTRL_OUTPUT_FORMAT];
    assign pllPinSelTxClk = ctrl[tcs_pkg::CTRL_PLL_PIN_SEL];
    assign lineMode = tcs_pkg::tcs_line_t'(mode[tcs_pkg::MODE_LINE_LSB +: 2]);
    assign tx_clock_loss_mode = mode[tcs_pkg::MODE_CLOCK_LOSS];
    assign isFramed = (lineMode == tcs_pkg::TCS_LINE_T1) || (lineMode == tcs_pkg::TCS_LINE_E1);

    // PLL domain: the PLL output is modelled as a divide-by-two of pllClk
    logic pllPhase;
    always_ff @(posedge pllClk or negedge reset_n) begin
        if (!reset_n) begin
            pllPhase <= 1'b0;
        end else begin
            pllPhase <= ~pllPhase;
        end
    end

    // clock, serial data and sync pin levels cross two flops before use; rxFrameLoss is registered once
    logic [4:0] syncedPins;
    logic pllLevel;
    logic primaryLevel;
    logic recoveredLevel;
    logic serialLevel;
    logic syncInLevel;

    tcs_sync2 #(
        .WIDTH(5)
    ) u_sync (
        .clk(mclk),
        .reset_n(reset_n),
        .asyncIn({pllPhase, tx_primary_clock_in, rxRecoveredClk, tx_serial_data_in, syncPinIn}),
        .syncOut(syncedPins)
    );

    assign pllLevel = syncedPins[4];
    assign primaryLevel = syncedPins[3];
    assign recoveredLevel = syncedPins[2];
    assign serialLevel = syncedPins[1];
    assign syncInLevel = syncedPins[0];

    // clock selection
    logic next_txClkLevel;
    logic txClkLevel;
    logic txClkPrev;
    logic txRise;
    logic txFall;

    always_comb begin
        next_txClkLevel = pllLevel;
        if (remoteLoopback) begin
            next_txClkLevel = recoveredLevel;
        end else begin
            case (clkSource)
                tcs_pkg::TCS_SRC_PLL: next_txClkLevel = pllLevel;
                tcs_pkg::TCS_SRC_PIN: next_txClkLevel = primaryLevel;
                tcs_pkg::TCS_SRC_RECOVERED: next_txClkLevel = recoveredLevel;
                default: next_txClkLevel = pllLevel;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txClkLevel <= 1'b0;
            txClkPrev <= 1'b0;
        end else begin
            txClkLevel <= next_txClkLevel;
            txClkPrev <= txClkLevel;
        end
    end

    assign txRise = txClkLevel & ~txClkPrev;
    assign txFall = ~txClkLevel & txClkPrev;

    // clock output pins follow one mclk late: tx_clock_out_pin the internal clock, pllClockOutPin the PLL level unless pllPinSelTxClk
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_clock_out_pin <= 1'b0;
            pllClockOutPin <= 1'b0;
        end else begin
            tx_clock_out_pin <= txClkLevel;
            pllClockOutPin <= pllPinSelTxClk ? txClkLevel : pllLevel;
        end
    end

    // serial data capture
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txDataBit <= 1'b0;
            txDataValid <= 1'b0;
        end else begin
            txDataValid <= txFall;
            if (txFall) begin
                txDataBit <= serialLevel;
            end
        end
    end

    // boundary counting
    logic [15:0] lastBit;
    logic [15:0] bitCount;
    logic syncInPrev;
    logic syncInPulse;
    logic atBoundary;

    assign lastBit = isFramed ? syncPeriod :
        (cc_boundary_select_bit ? tcs_pkg::CC_400_LAST : tcs_pkg::CC_8K_LAST);
    assign atBoundary = (bitCount == 16'h0000);
    // a pulse is a low-to-high change seen across two falling edges
    assign syncInPulse = txFall & syncInLevel & ~syncInPrev & ~syncIsOutput;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncInPrev <= 1'b0;
            bitCount <= 16'h0000;
            txFrameStart <= 1'b0;
        end else begin
            txFrameStart <= 1'b0;
            if (txFall) begin
                syncInPrev <= syncInLevel;
                if (syncInPulse) begin
                    // input pulse sets boundary
                    // the pulse fall is bit 0, as a wrap fall is, so frames keep their length
                    bitCount <= 16'h0000;
                    txFrameStart <= 1'b1;
                end else if (bitCount >= lastBit) begin
                    bitCount <= 16'h0000;
                    txFrameStart <= 1'b1;
                end else begin
                    bitCount <= bitCount + 16'h0001;
                end
            end
        end
    end

    // sync pin as output
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_boundary_sync_pin <= 1'b0;
            syncPinOe <= 1'b0;
        end else begin
            syncPinOe <= syncIsOutput && (lineMode != tcs_pkg::TCS_LINE_6312);
            if (!syncIsOutput) begin
                tx_boundary_sync_pin <= 1'b0;
            end else if (txRise) begin
                tx_boundary_sync_pin <= atBoundary && (lineMode != tcs_pkg::TCS_LINE_6312);
            end
        end
    end

    // line data rails
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_positive_rail_out <= 1'b0;
            tx_negative_rail_out <= 1'b0;
        end else if (!isFramed) begin
            tx_positive_rail_out <= 1'b0;
            tx_negative_rail_out <= 1'b0;
        end else if (txRise) begin
            tx_positive_rail_out <= output_format_select_bit ? fmtNrz : fmtPos;
            tx_negative_rail_out <= fmtNeg;
        end
    end

    // loss of transmit clock watch on the primary clock pin
    logic primaryPrev;
    logic [11:0] idleCount;
    logic clockLost;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            primaryPrev <= 1'b0;
            idleCount <= tcs_pkg::LOSS_COUNT_RESET;
            clockLost <= 1'b0;
        end else begin
            primaryPrev <= primaryLevel;
            if (primaryLevel != primaryPrev) begin
                idleCount <= tcs_pkg::LOSS_COUNT_RESET;
                clockLost <= 1'b0;
            end else if (idleCount >= tcs_pkg::LOSS_CYCLES) begin
                clockLost <= 1'b1;
            end else begin
                idleCount <= idleCount + 12'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            frame_loss_indicator_pin <= 1'b0;
        end else if (lineMode == tcs_pkg::TCS_LINE_6312) begin
            frame_loss_indicator_pin <= 1'b0;
        end else if (isFramed && tx_clock_loss_mode) begin
            frame_loss_indicator_pin <= clockLost;
        end else begin
            frame_loss_indicator_pin <= rxFrameLoss;
        end
    end

    // register writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= tcs_pkg::CTRL_RESET;
            mode <= tcs_pkg::MODE_RESET;
            syncPeriod <= tcs_pkg::PERIOD_RESET;
        end else if (regWrite) begin
            case (regAddr)
                tcs_pkg::ADDR_CTRL: ctrl <= regWrData;
                tcs_pkg::ADDR_MODE: mode <= {5'h00, regWrData[2:0]};
                tcs_pkg::ADDR_PERIOD_LO: syncPeriod[7:0] <= regWrData;
                tcs_pkg::ADDR_PERIOD_HI: syncPeriod[15:8] <= regWrData;
                default: ;
            endcase
        end
    end

    // register reads, answered in the next cycle only
    logic [7:0] next_regRdData;
    logic [7:0] statusWord;

    always_comb begin
        statusWord = 8'h00;
        statusWord[tcs_pkg::STAT_CLOCK_LOSS] = clockLost;
        statusWord[tcs_pkg::STAT_SYNC_LEVEL] = syncInLevel;
        statusWord[tcs_pkg::STAT_TXCLK_LEVEL] = txClkLevel;
        statusWord[tcs_pkg::STAT_PLL_LEVEL] = pllLevel;
        next_regRdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                tcs_pkg::ADDR_CTRL: next_regRdData = ctrl;
                tcs_pkg::ADDR_MODE: next_regRdData = mode;
                tcs_pkg::ADDR_PERIOD_LO: next_regRdData = syncPeriod[7:0];
                tcs_pkg::ADDR_PERIOD_HI: next_regRdData = syncPeriod[15:8];
                tcs_pkg::ADDR_STATUS: next_regRdData = statusWord;
                tcs_pkg::ADDR_COUNT_LO: next_regRdData = bitCount[7:0];
                tcs_pkg::ADDR_COUNT_HI: next_regRdData = bitCount[15:8];
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_regRdData;
        end
    end

endmodule // tcs_tx_interface
`default_nettype wire

/* File: tcs_tx_sva.sv */
// port assertions of the transmit clock and sync interface
`timescale 1ns/100ps
`default_nettype none
module tcs_tx_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register writes
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    // watched outputs
    input wire logic tx_clock_out_pin,
    input wire logic tx_boundary_sync_pin,
    input wire logic syncPinOe,
    input wire logic tx_positive_rail_out,
    input wire logic tx_negative_rail_out,
    input wire logic frame_loss_indicator_pin,
    input wire logic txDataBit,
    input wire logic txDataValid
);
    logic [7:0] ctrlR;
    logic [2:0] modeR;
    // shadow copies of control and mode, same write timing as the block
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlR <= tcs_pkg::CTRL_RESET;
            modeR <= 3'h0;
        end else if (regWrite && regAddr == tcs_pkg::ADDR_CTRL) begin
            ctrlR <= regWrData;
        end else if (regWrite && regAddr == tcs_pkg::ADDR_MODE) begin
            modeR <= regWrData[2:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_DV_PULSE: assert property (txDataValid |=> !txDataValid)
        else $error("data valid longer than one cycle");
    AST_DV_FALL: assert property (txDataValid && !ctrlR[2] |-> $fell(tx_clock_out_pin))
        else $error("data taken away from a clock fall");
    AST_BIT_HOLD: assert property ($changed(txDataBit) |-> txDataValid)
        else $error("data bit moved without a sample");
    AST_RAIL_EDGE: assert property (!modeR[1] && !$past(modeR[1], 2) && !ctrlR[2]
        && ctrlR == $past(ctrlR, 2) && !$stable({tx_positive_rail_out, tx_negative_rail_out})
        |-> $rose(tx_clock_out_pin)) else $error("rails moved off a clock rise");
    AST_RAILS_LOW: assert property (modeR[1] && $past(modeR[1]) && $past(modeR[1], 2)
        |-> !tx_positive_rail_out && !tx_negative_rail_out) else $error("rails not low");
    AST_OE_OFF: assert property (!ctrlR[3] && !$past(ctrlR[3]) && !$past(ctrlR[3], 2)
        |-> !syncPinOe) else $error("sync driver on in input mode");
    AST_FLAG_6312: assert property (modeR[1:0] == 2'h3 && $past(modeR[1:0], 2) == 2'h3
        |-> !frame_loss_indicator_pin && !syncPinOe) else $error("6312 outputs not idle");
    AST_SYNC_EDGE: assert property (syncPinOe && $past(syncPinOe) && !ctrlR[2]
        && $changed(tx_boundary_sync_pin) |-> $rose(tx_clock_out_pin))
        else $error("sync output moved off a clock rise");
endmodule // tcs_tx_sva
`default_nettype wire

/* File: tcs_sys_model.sv */
// system-side framing model: transmit clock, serial data and sync pulse
`timescale 1ns/100ps
`default_nettype none
module tcs_sys_model #(
    parameter int HALF_NS = 80
) (
    // bench control
    input wire logic run,
    input wire logic syncReq,
    // pins toward the block
    output logic txClk,
    output logic txData,
    output logic syncPulse
);
    logic [7:0] pattern = 8'hB4;
    // primary clock supply
    // stands still low while run is off, as between frames
    initial begin
        txClk = 1'b0;
        txData = 1'b0;
        syncPulse = 1'b0;
        forever begin
            wait (run === 1'b1);
            #(HALF_NS);
            txClk = 1'b1;
            // valid at fall
            // data and sync move at the rise, half a period before they are taken
            pattern <= {pattern[6:0], pattern[7]};
            txData <= pattern[7];
            syncPulse <= syncReq;
            #(HALF_NS) txClk = 1'b0;
        end
    end
endmodule // tcs_sys_model
`default_nettype wire

/* File: tcs_tx_interface_tb.sv */
// self-checking bench of the transmit clock and sync interface
`timescale 1ns/100ps
`default_nettype none
module tcs_tx_interface_tb;
    logic mclk, reset_n, pllClk, recClk, run, syncReq, rxFrameLoss, regWrite, regRead;
    logic fmtPos, fmtNeg, fmtNrz, txCkIn, serIn, sysSync, syncWire, ckOut, pllOut;
    logic syncOut, syncOe, pos, neg, flag, dBit, dValid, fStart;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData;
    int n_fail = 0;
    int num_checks = 0;
    assign syncWire = syncOe ? syncOut : sysSync;
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        pllClk = 1'b0;
        #3.3;
        forever #7.5 pllClk = ~pllClk;
    end
    initial begin
        recClk = 1'b0;
        forever #48 recClk = ~recClk;
    end
    tcs_sys_model u_sys (.run(run), .syncReq(syncReq), .txClk(txCkIn), .txData(serIn),
        .syncPulse(sysSync));
    tcs_tx_interface u_dut (.mclk(mclk), .reset_n(reset_n), .pllClk(pllClk),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .tx_primary_clock_in(txCkIn), .rxRecoveredClk(recClk),
        .tx_clock_out_pin(ckOut), .pllClockOutPin(pllOut), .tx_serial_data_in(serIn),
        .syncPinIn(syncWire), .tx_boundary_sync_pin(syncOut), .syncPinOe(syncOe),
        .tx_positive_rail_out(pos), .tx_negative_rail_out(neg), .rxFrameLoss(rxFrameLoss),
        .frame_loss_indicator_pin(flag), .fmtPos(fmtPos), .fmtNeg(fmtNeg), .fmtNrz(fmtNrz),
        .txDataBit(dBit), .txDataValid(dValid), .txFrameStart(fStart));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // counts are judged with a small margin for synchroniser jitter
    task automatic near(input int got, input int e);
        chk(16'(got > e - 4 && got < e + 4 ? e : got), 16'(e));
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    // waits for a level on one output, counting samples and clock-out rises
    task automatic waitFor(input int sel, input logic lvl, input int lim,
        output int nv, output int nr);
        logic s;
        logic prev;
        nv = 0;
        nr = 0;
        prev = ckOut;
        for (int i = 0; i < lim; i++) begin
            @(negedge mclk);
            s = sel == 0 ? fStart : sel == 1 ? syncOut : sel == 2 ? flag : sysSync;
            nv += int'(dValid === 1'b1);
            nr += int'(ckOut === 1'b1 && prev === 1'b0);
            prev = ckOut;
            if (s === lvl) return;
        end
        chk(16'(s), 16'(lvl));
        complete_run();
    endtask
    task automatic test_regs;
        logic [7:0] d;
        rd(tcs_pkg::ADDR_CTRL, d);
        chk(16'(d), 16'(tcs_pkg::CTRL_RESET));
        chk(16'(syncOe), 16'h0000);
        rd(tcs_pkg::ADDR_PERIOD_LO, d);
        chk(16'(d), 16'h00C0);
        rd(4'hF, d);
        chk(16'(d), 16'h0000);
        $display("test regs done");
    endtask
    task automatic test_data;
        int k = 0;
        wr(tcs_pkg::ADDR_CTRL, 8'h01);
        // a source switch can make one early fall on stale data
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 600 && k < 16; i++) begin
            @(negedge mclk);
            if (dValid === 1'b1) begin
                k++;
                chk(16'(dBit), 16'(serIn));
            end
        end
        chk(16'(k), 16'h0010);
        $display("test data done");
    endtask
    task automatic test_clock_sel;
        logic [7:0] ct [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h41, 8'h03};
        int pc [6] = '{30, 160, 96, 96, 160, 30};
        int pp [6] = '{30, 30, 30, 30, 160, 30};
        int nc;
        int np;
        logic c0;
        logic p0;
        for (int i = 0; i < 6; i++) begin
            wr(tcs_pkg::ADDR_CTRL, ct[i]);
            repeat (20) @(posedge mclk);
            nc = 0;
            np = 0;
            c0 = ckOut;
            p0 = pllOut;
            repeat (4000) begin
                @(negedge mclk);
                nc += int'(ckOut === 1'b1 && c0 === 1'b0);
                np += int'(pllOut === 1'b1 && p0 === 1'b0);
                c0 = ckOut;
                p0 = pllOut;
            end
            near(nc, 32000 / pc[i]);
            near(np, 32000 / pp[i]);
        end
        $display("test clock select done");
    endtask
    task automatic test_rails;
        logic [7:0] md [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03};
        logic [7:0] ct [6] = '{8'h01, 8'h01, 8'h21, 8'h21, 8'h01, 8'h01};
        logic [2:0] fm [6] = '{3'h4, 3'h2, 3'h1, 3'h6, 3'h7, 3'h7};
        logic [1:0] ex [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 6; i++) begin
            wr(tcs_pkg::ADDR_MODE, md[i]);
            wr(tcs_pkg::ADDR_CTRL, ct[i]);
            @(posedge mclk);
            {fmtPos, fmtNeg, fmtNrz} <= fm[i];
            repeat (60) @(posedge mclk);
            @(negedge mclk);
            chk(16'({pos, neg}), 16'(ex[i]));
        end
        $display("test rails done");
    endtask
    // period register 3 gives a four-bit frame in T1
    task automatic test_sync(input logic out, input logic [7:0] md, input logic [7:0] ct,
        input int gap);
        int nv;
        int nr;
        int n2;
        wr(tcs_pkg::ADDR_PERIOD_LO, out ? 8'h03 : 8'h09);
        wr(tcs_pkg::ADDR_MODE, md);
        wr(tcs_pkg::ADDR_CTRL, ct);
        if (out) begin
            waitFor(1, 1'b0, 4000, nv, nr);
            waitFor(1, 1'b1, 4000, nv, nr);
            waitFor(1, 1'b0, 400, nv, nr);
            waitFor(1, 1'b1, 4000, nv, n2);
            chk(16'(nr + n2), 16'(gap));
            chk(16'(syncOe), 16'h0001);
        end else begin
            repeat (100) @(posedge mclk);
            syncReq <= 1'b1;
            waitFor(3, 1'b1, 100, nv, nr);
            syncReq <= 1'b0;
            waitFor(0, 1'b1, 200, nv, nr);
            chk(16'(nv < 4 ? 0 : nv), 16'h0000);
            waitFor(0, 1'b0, 10, nv, nr);
            waitFor(0, 1'b1, 5000, nv, nr);
            chk(16'(nv), 16'(gap));
        end
        $display("test sync done");
    endtask
    task automatic test_flag;
        int el;
        int t0;
        int nv;
        int nr;
        logic ck;
        logic [7:0] d;
        wr(tcs_pkg::ADDR_MODE, 8'h04);
        wr(tcs_pkg::ADDR_CTRL, 8'h01);
        repeat (100) @(posedge mclk);
        chk(16'(flag), 16'h0000);
        run <= 1'b0;
        t0 = int'($time);
        ck = txCkIn;
        // the clock ends its period first; time the idle from its last edge
        for (int i = 0; i < 25; i++) begin
            @(negedge mclk);
            if (txCkIn !== ck) begin
                t0 = int'($time);
            end
            ck = txCkIn;
        end
        waitFor(2, 1'b1, 2000, nv, nr);
        el = (int'($time) - t0) / 8;
        near(el, tcs_pkg::LOSS_CYCLES_INT + 5);
        rd(tcs_pkg::ADDR_STATUS, d);
        chk(16'(d[tcs_pkg::STAT_CLOCK_LOSS]), 16'h0001);
        @(posedge mclk);
        run <= 1'b1;
        wr(tcs_pkg::ADDR_MODE, 8'h00);
        rxFrameLoss <= 1'b1;
        repeat (50) @(posedge mclk);
        chk(16'(flag), 16'h0001);
        wr(tcs_pkg::ADDR_MODE, 8'h03);
        repeat (10) @(posedge mclk);
        chk(16'(flag), 16'h0000);
        rxFrameLoss <= 1'b0;
        $display("test flag done");
    endtask
    initial begin
        {reset_n, run, syncReq, rxFrameLoss, regWrite, regRead} = 6'h10;
        {fmtPos, fmtNeg, fmtNrz, regAddr, regWrData} = 15'h0000;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        test_regs();
        test_data();
        test_clock_sel();
        test_rails();
        test_sync(1'b1, 8'h00, 8'h09, 4);
        test_sync(1'b1, 8'h02, 8'h09, 8);
        test_sync(1'b1, 8'h02, 8'h19, 160);
        test_sync(1'b0, 8'h00, 8'h01, 10);
        test_sync(1'b0, 8'h02, 8'h01, 8);
        test_sync(1'b0, 8'h02, 8'h11, 160);
        test_flag();
        complete_run();
    end
endmodule // tcs_tx_interface_tb
bind tcs_tx_interface tcs_tx_sva u_sva (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .tx_clock_out_pin(tx_clock_out_pin),
    .tx_boundary_sync_pin(tx_boundary_sync_pin), .syncPinOe(syncPinOe),
    .tx_positive_rail_out(tx_positive_rail_out),
    .tx_negative_rail_out(tx_negative_rail_out),
    .frame_loss_indicator_pin(frame_loss_indicator_pin), .txDataBit(txDataBit),
    .txDataValid(txDataValid));
`default_nettype wire
